/* cap_params.svh */
// Constants of the command/address parity checker and its controller end.
// Assumes a single 250 MHz command clock shared by both ends.
`ifndef CAP_PARAMS_SVH
`define CAP_PARAMS_SVH

`define CAP_CLK_MHZ 250
// Round a least time up and a longest time down to whole cycles, never below one
`define CAP_CEIL(ns) (((ns) * `CAP_CLK_MHZ + 999) / 1000 < 1 ? 1 : ((ns) * `CAP_CLK_MHZ + 999) / 1000)
`define CAP_FLOOR(ns) (((ns) * `CAP_CLK_MHZ) / 1000 < 1 ? 1 : ((ns) * `CAP_CLK_MHZ) / 1000)

`define CAP_ERR_ON_NS 12
`define CAP_PW_MIN_NS 72
`define CAP_PW_MAX_NS 144
`define CAP_ROW_ACTIVE_NS 32
`define CAP_MODE_SET_NS 24
`define CAP_REL_EXTRA_NS 3
`define CAP_ERR_ON_CYC `CAP_FLOOR(`CAP_ERR_ON_NS)
`define CAP_PW_MIN_CYC `CAP_CEIL(`CAP_PW_MIN_NS)
`define CAP_PW_MAX_CYC `CAP_FLOOR(`CAP_PW_MAX_NS)
`define CAP_ROW_ACTIVE_CYC `CAP_CEIL(`CAP_ROW_ACTIVE_NS)
`define CAP_MODE_SET_CYC `CAP_CEIL(`CAP_MODE_SET_NS)
`define CAP_REL_CYC (1 + `CAP_CEIL(`CAP_REL_EXTRA_NS))
`define CAP_GAP_CYC 1
`define CAP_EXTRA_REFRESH 2

// Mode register five select on {bank group, bank}, and its fields
`define CAP_MR5_SEL 4'h5
`define CAP_LOG_SEL 4'hf
`define CAP_PL_LSB 0
`define CAP_STAT_BIT 4
`define CAP_PERS_BIT 9

// Controller register offsets
`define CAP_REG_CMD 4'h0
`define CAP_REG_STATUS 4'h4
`define CAP_REG_READOUT 4'h8
`define CAP_REG_PL 4'hc
`define CAP_PL_RESET 3'h0

`endif

/* cap_pkg.sv */
// Types shared by the parity checker, its controller end and the link.
package cap_pkg;
   typedef struct packed {
      logic act_n;
      logic ras;
      logic cas;
      logic we;
      logic [1:0] bg;
      logic [1:0] ba;
      logic [13:0] addr;
   } cap_cmd_s;

   // {act_n, ras, cas, we}; any code with act_n low is an activate
   typedef enum logic [3:0] {
      CAP_MRS = 4'h8,
      CAP_REF = 4'h9,
      CAP_PRE = 4'ha,
      CAP_WR = 4'hc,
      CAP_RD = 4'hd
   } cap_op_e;

   typedef enum logic [1:0] {
      DS_IDLE = 2'b00,
      DS_ALERT = 2'b01,
      DS_TAIL = 2'b10
   } cap_dev_state_e;

   typedef enum logic [1:0] {
      HS_IDLE = 2'b00,
      HS_WAIT = 2'b01,
      HS_ALERT = 2'b10,
      HS_RELEASE = 2'b11
   } cap_host_state_e;
endpackage

/* cap_if.sv */
// Command/address link between controller and memory device.
// Both ends run on the same command clock; no clocking block.
`timescale 1ns/1ns
`default_nettype none
interface cap_if;
   logic cs_n;
   cap_pkg::cap_cmd_s ca;
   logic cmd_parity_in;
   logic alert_n;
   logic [31:0] rd_data;
   logic rd_valid;

   modport dev(input cs_n, input ca, input cmd_parity_in, output alert_n, output rd_data, output rd_valid);
   modport host(output cs_n, output ca, output cmd_parity_in, input alert_n, input rd_data, input rd_valid);
endinterface
`default_nettype wire

/* cap_device.sv */
// Device end: parity check of captured commands, parity latency, error pulse.
// Assumes the controller end on the same clock keeps its own timing duties.
`include "cap_params.svh"
`timescale 1ns/1ns
`default_nettype none
module cap_device (
   input wire logic CLOCK_I,
   input wire logic NRST_I,
   cap_if.dev BUS,
   input wire logic [4:0] ADDED_LAT_I,
   input wire logic [4:0] WRITE_CAS_LAT_I,
   input wire logic [4:0] READ_CAS_LAT_I,
   output logic EXEC_VALID_O,
   output cap_pkg::cap_cmd_s EXEC_CMD_O,
   output logic PRECHARGE_ALL_O,
   output logic CHECK_ON_O,
   output logic [6:0] WRITE_LAT_O,
   output logic [6:0] READ_LAT_O
);
   localparam int DEPTH = 7;
   localparam logic [7:0] ON_CYC = 8'(`CAP_ERR_ON_CYC);
   localparam logic [7:0] PW_MIN = 8'(`CAP_PW_MIN_CYC);
   localparam logic [7:0] PW_END = ON_CYC + 8'(`CAP_PW_MAX_CYC);
   localparam logic [7:0] ROW_CYC = 8'(`CAP_ROW_ACTIVE_CYC);

   // Absent stacking pins are simply not inputs here, so they add nothing
   function automatic logic parity_of(input cap_pkg::cap_cmd_s c);
      parity_of = ^c;
   endfunction

   function automatic logic is_mr5(input cap_pkg::cap_cmd_s c);
      is_mr5 = ({c.act_n, c.ras, c.cas, c.we} == cap_pkg::CAP_MRS) && ({c.bg, c.ba} == `CAP_MR5_SEL);
   endfunction

   cap_pkg::cap_dev_state_e state_q;
   logic [7:0] cnt_q;
   logic [2:0] pl_q;
   logic pers_q;
   logic status_q;
   logic multi_q;
   logic prech_done_q;
   logic alert_n_q;
   logic rd_valid_q;
   logic [31:0] rd_data_q;
   cap_pkg::cap_cmd_s log_q;
   cap_pkg::cap_cmd_s pipe_q [DEPTH:0];
   logic pipe_v_q [DEPTH:0];
   logic idle;
   logic check_on;
   logic par_err;
   logic accept;
   logic exec_v;
   cap_pkg::cap_cmd_s exec_c;
   logic clr_status;

   assign idle = (state_q == cap_pkg::DS_IDLE);
   assign check_on = (pl_q != 3'h0) && idle && (!status_q || pers_q);
   assign par_err = !BUS.cs_n && check_on && (parity_of(BUS.ca) ^ BUS.cmd_parity_in);
   assign accept = !BUS.cs_n && idle && !par_err;
   assign exec_v = (pl_q == 3'h0) ? accept : pipe_v_q[pl_q];
   assign exec_c = (pl_q == 3'h0) ? BUS.ca : pipe_q[pl_q];
   // A one in the status field is ignored: only a clear takes effect
   assign clr_status = exec_v && is_mr5(exec_c) && !exec_c.addr[`CAP_STAT_BIT];

   assign pipe_q[0] = BUS.ca;
   assign pipe_v_q[0] = accept;

   // Latency line; an error flushes the uncertain window, so no read there reaches the strobes
   genvar k;
   generate
      for (k = 1; k <= DEPTH; k++) begin : g_stage
         always_ff @(posedge CLOCK_I) begin
            if (!NRST_I) begin
               pipe_v_q[k] <= 1'b0;
               pipe_q[k] <= '0;
            end else begin
               pipe_v_q[k] <= pipe_v_q[k-1] && idle && !par_err;
               pipe_q[k] <= pipe_q[k-1];
            end
         end
      end
   endgenerate

   always_ff @(posedge CLOCK_I) begin
      if (!NRST_I) begin
         EXEC_VALID_O <= 1'b0;
         EXEC_CMD_O <= '0;
      end else begin
         EXEC_VALID_O <= exec_v && idle;
         EXEC_CMD_O <= exec_c;
      end
   end

   // Mode register five: latency and persistence taken as the command executes
   always_ff @(posedge CLOCK_I) begin
      if (!NRST_I) begin
         pl_q <= `CAP_PL_RESET;
         pers_q <= 1'b0;
      end else if (exec_v && idle && is_mr5(exec_c)) begin
         pl_q <= exec_c.addr[`CAP_PL_LSB +: 3];
         pers_q <= exec_c.addr[`CAP_PERS_BIT];
      end
   end

   // Set wins over a clear arriving in the same cycle
   always_ff @(posedge CLOCK_I) begin
      if (!NRST_I) begin
         status_q <= 1'b0;
         multi_q <= 1'b0;
      end else if (par_err) begin
         status_q <= 1'b1;
         multi_q <= multi_q || status_q;
      end else if (clr_status && idle) begin
         status_q <= 1'b0;
         multi_q <= 1'b0;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (!NRST_I) begin
         log_q <= '0;
      end else if (par_err) begin
         log_q <= BUS.ca;
      end
   end

   // Error pulse: alert low from the cycle after the error, well inside the assert delay
   always_ff @(posedge CLOCK_I) begin
      if (!NRST_I) begin
         state_q <= cap_pkg::DS_IDLE;
         cnt_q <= 8'h00;
         alert_n_q <= 1'b1;
         prech_done_q <= 1'b0;
         PRECHARGE_ALL_O <= 1'b0;
      end else begin
         PRECHARGE_ALL_O <= 1'b0;
         unique case (state_q)
            cap_pkg::DS_IDLE: begin
               if (par_err) begin
                  state_q <= cap_pkg::DS_ALERT;
                  cnt_q <= 8'h01;
                  alert_n_q <= 1'b0;
                  prech_done_q <= 1'b0;
               end
            end
            cap_pkg::DS_ALERT: begin
               cnt_q <= cnt_q + 8'h01;
               if (cnt_q == ROW_CYC) begin
                  PRECHARGE_ALL_O <= 1'b1;
                  prech_done_q <= 1'b1;
               end
               if (cnt_q >= PW_MIN && prech_done_q) begin
                  state_q <= cap_pkg::DS_TAIL;
                  alert_n_q <= 1'b1;
               end
            end
            cap_pkg::DS_TAIL: begin
               cnt_q <= cnt_q + 8'h01;
               if (cnt_q >= PW_END) begin
                  state_q <= cap_pkg::DS_IDLE;
               end
            end
            default: begin
               state_q <= cap_pkg::DS_IDLE;
               alert_n_q <= 1'b1;
            end
         endcase
      end
   end

   // Log readout: a read addressed to the log select returns status and log
   always_ff @(posedge CLOCK_I) begin
      if (!NRST_I) begin
         rd_valid_q <= 1'b0;
         rd_data_q <= 32'h0;
      end else begin
         rd_valid_q <= exec_v && idle && ({exec_c.act_n, exec_c.ras, exec_c.cas, exec_c.we} == cap_pkg::CAP_RD)
                       && ({exec_c.bg, exec_c.ba} == `CAP_LOG_SEL);
         rd_data_q <= {8'h00, multi_q, status_q, log_q};
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (!NRST_I) begin
         WRITE_LAT_O <= 7'h00;
         READ_LAT_O <= 7'h00;
         CHECK_ON_O <= 1'b0;
      end else begin
         WRITE_LAT_O <= 7'(ADDED_LAT_I) + 7'(WRITE_CAS_LAT_I) + 7'(pl_q);
         READ_LAT_O <= 7'(ADDED_LAT_I) + 7'(READ_CAS_LAT_I) + 7'(pl_q);
         CHECK_ON_O <= check_on;
      end
   end

   assign BUS.alert_n = alert_n_q;
   assign BUS.rd_valid = rd_valid_q;
   assign BUS.rd_data = rd_data_q;
endmodule
`default_nettype wire

/* cap_host.sv */
// Controller end: issues commands with even parity and reacts to the error pulse.
// Assumes the device end on the same clock; software uses a plain register port.
`include "cap_params.svh"
`timescale 1ns/1ns
`default_nettype none
module cap_host (
   input wire logic CLOCK_I,
   input wire logic NRST_I,
   cap_if.host BUS,
   input wire logic [3:0] ADDR_I,
   input wire logic [31:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [31:0] RDATA_O
);
   localparam logic [7:0] GAP = 8'(`CAP_GAP_CYC);
   localparam logic [7:0] MOD_CYC = 8'(`CAP_MODE_SET_CYC);
   localparam logic [7:0] REL_CYC = 8'(`CAP_REL_CYC);
   localparam logic [1:0] N_REF = 2'(`CAP_EXTRA_REFRESH);

   cap_pkg::cap_host_state_e state_q;
   logic [7:0] cnt_q;
   logic pend_q;
   cap_pkg::cap_cmd_s pend_cmd_q;
   logic [2:0] pl_q;
   logic [1:0] ref_owed_q;
   logic alert_seen_q;
   logic refused_q;
   logic [31:0] readout_q;
   logic cs_n_q;
   logic par_q;
   cap_pkg::cap_cmd_s ca_q;
   logic new_mr5;
   logic [2:0] new_pl;
   logic need_zero;
   cap_pkg::cap_cmd_s out_c;
   cap_pkg::cap_cmd_s ref_c;
   logic go;

   assign new_mr5 = ({pend_cmd_q.act_n, pend_cmd_q.ras, pend_cmd_q.cas, pend_cmd_q.we} == cap_pkg::CAP_MRS)
                    && ({pend_cmd_q.bg, pend_cmd_q.ba} == `CAP_MR5_SEL);
   assign new_pl = pend_cmd_q.addr[`CAP_PL_LSB +: 3];
   // Going straight between two nonzero latencies is illegal, so disable first
   assign need_zero = new_mr5 && (pl_q != 3'h0) && (new_pl != 3'h0) && (new_pl != pl_q);
   assign ref_c = '{act_n: 1'b1, ras: 1'b0, cas: 1'b0, we: 1'b1, bg: 2'b00, ba: 2'b00, addr: 14'h0000};
   always_comb begin
      out_c = pend_cmd_q;
      if (ref_owed_q != 2'h0) begin
         out_c = ref_c;
      end else if (need_zero) begin
         out_c.addr[`CAP_PL_LSB +: 3] = 3'h0;
      end
   end
   assign go = (state_q == cap_pkg::HS_IDLE) && BUS.alert_n && (pend_q || ref_owed_q != 2'h0);

   always_ff @(posedge CLOCK_I) begin
      if (!NRST_I) begin
         state_q <= cap_pkg::HS_IDLE;
         cnt_q <= 8'h00;
         cs_n_q <= 1'b1;
         ca_q <= '0;
         par_q <= 1'b0;
         pl_q <= `CAP_PL_RESET;
         ref_owed_q <= 2'h0;
      end else begin
         cs_n_q <= 1'b1;
         if (!BUS.alert_n && state_q != cap_pkg::HS_ALERT) begin
            state_q <= cap_pkg::HS_ALERT;
         end else begin
            unique case (state_q)
               cap_pkg::HS_IDLE: begin
                  if (go) begin
                     cs_n_q <= 1'b0;
                     ca_q <= out_c;
                     par_q <= ^out_c;
                     state_q <= cap_pkg::HS_WAIT;
                     if (ref_owed_q != 2'h0) begin
                        ref_owed_q <= ref_owed_q - 2'h1;
                        cnt_q <= GAP;
                     end else if (new_mr5) begin
                        pl_q <= out_c.addr[`CAP_PL_LSB +: 3];
                        // Wait covers the mode set time plus the old and the new latency added together
                        cnt_q <= MOD_CYC + 8'(pl_q) + 8'(out_c.addr[`CAP_PL_LSB +: 3]);
                     end else begin
                        cnt_q <= GAP;
                     end
                  end
               end
               cap_pkg::HS_WAIT: begin
                  cnt_q <= cnt_q - 8'h01;
                  if (cnt_q <= 8'h01) begin
                     state_q <= cap_pkg::HS_IDLE;
                  end
               end
               cap_pkg::HS_ALERT: begin
                  if (BUS.alert_n) begin
                     state_q <= cap_pkg::HS_RELEASE;
                     cnt_q <= REL_CYC;
                  end
               end
               cap_pkg::HS_RELEASE: begin
                  cnt_q <= cnt_q - 8'h01;
                  if (cnt_q <= 8'h01) begin
                     state_q <= cap_pkg::HS_IDLE;
                     ref_owed_q <= N_REF;
                  end
               end
            endcase
         end
      end
   end

   // Pending command from software; a send clears it unless it was a refresh or the disabling step
   always_ff @(posedge CLOCK_I) begin
      if (!NRST_I) begin
         pend_q <= 1'b0;
         pend_cmd_q <= '0;
         refused_q <= 1'b0;
      end else begin
         if (go && ref_owed_q == 2'h0 && !need_zero) begin
            pend_q <= 1'b0;
         end
         if (WR_I && ADDR_I == `CAP_REG_CMD) begin
            if (pend_q) begin
               refused_q <= 1'b1;
            end else begin
               pend_q <= 1'b1;
               pend_cmd_q <= WDATA_I[21:0];
            end
         end else if (WR_I && ADDR_I == `CAP_REG_STATUS && WDATA_I[2]) begin
            refused_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (!NRST_I) begin
         alert_seen_q <= 1'b0;
         readout_q <= 32'h0;
      end else begin
         if (!BUS.alert_n) begin
            alert_seen_q <= 1'b1;
         end else if (WR_I && ADDR_I == `CAP_REG_STATUS && WDATA_I[1]) begin
            alert_seen_q <= 1'b0;
         end
         if (BUS.rd_valid) begin
            readout_q <= BUS.rd_data;
         end
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (!NRST_I) begin
         RDATA_O <= 32'h0;
      end else if (RD_I) begin
         unique case (ADDR_I)
            `CAP_REG_STATUS: RDATA_O <= {28'h0, ref_owed_q != 2'h0, refused_q, alert_seen_q, pend_q};
            `CAP_REG_READOUT: RDATA_O <= readout_q;
            `CAP_REG_PL: RDATA_O <= {29'h0, pl_q};
            default: RDATA_O <= 32'h0;
         endcase
      end else begin
         RDATA_O <= 32'h0;
      end
   end

   assign BUS.cs_n = cs_n_q;
   assign BUS.ca = ca_q;
   assign BUS.cmd_parity_in = par_q;
endmodule
`default_nettype wire

/* cap_assertions.sv */
// Checker for the link joining the controller end to the device end.
// Assumes one command clock and a synchronous active-low reset.
`include "cap_params.svh"
`timescale 1ns/1ns
`default_nettype none
module cap_assertions (
   input wire logic CLOCK_I,
   input wire logic NRST_I,
   input wire logic cs_n,
   input wire cap_pkg::cap_cmd_s ca,
   input wire logic cmd_parity_in,
   input wire logic dev_parity_in,
   input wire logic alert_n,
   input wire logic [31:0] rd_data,
   input wire logic rd_valid
);
   localparam int PW_MIN = `CAP_PW_MIN_CYC;
   localparam int PW_LIM = `CAP_ERR_ON_CYC + `CAP_PW_MAX_CYC;
   logic [7:0] low_q;
   logic [2:0] pl_q;
   logic mrs5;
   assign mrs5 = !cs_n && {ca.act_n, ca.ras, ca.cas, ca.we} == cap_pkg::CAP_MRS && {ca.bg, ca.ba} == `CAP_MR5_SEL;
   // Saturates so a stuck alert cannot wrap back into range
   always_ff @(posedge CLOCK_I) begin
      if (!NRST_I || alert_n) begin
         low_q <= 8'h00;
      end else if (low_q != 8'hff) begin
         low_q <= low_q + 8'h01;
      end
   end
   always_ff @(posedge CLOCK_I) begin
      if (!NRST_I) begin
         pl_q <= 3'h0;
      end else if (mrs5) begin
         pl_q <= ca.addr[2:0];
      end
   end
   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (!NRST_I);
   parity_even_a: assert property (!cs_n |-> !(^{ca, cmd_parity_in}))
      else $error("odd parity on the link");
   deselect_gap_a: assert property (!cs_n |=> cs_n)
      else $error("commands without a deselect between");
   alert_cause_a: assert property ($fell(alert_n) |-> $past(!cs_n && (^{ca, dev_parity_in})))
      else $error("alert without a bad command");
   alert_min_a: assert property (!alert_n && low_q < PW_MIN - 1 |=> !alert_n)
      else $error("alert released too early");
   alert_max_a: assert property (!alert_n |-> low_q < PW_LIM)
      else $error("alert held too long");
   alert_quiet_a: assert property ($past(!alert_n) && !alert_n |-> cs_n)
      else $error("command during alert");
   release_quiet_a: assert property ($rose(alert_n) |-> cs_n ##1 cs_n)
      else $error("command right after alert release");
   latency_change_a: assert property (mrs5 && ca.addr[2:0] != 3'h0 |-> pl_q == 3'h0)
      else $error("latency changed without disabling");
   mode_wait_a: assert property (mrs5 |=> cs_n [*6])
      else $error("command too soon after mode set");
   cover property (mrs5 && ca.addr[2:0] != 3'h0);
   cover property (!cs_n && !mrs5);
   cover property (rd_valid && rd_data[22]);
   cover property ($rose(alert_n));
endmodule
`default_nettype wire

/* cmd_addr_parity_checker_tb.sv */
// Bench: controller end joined to one device through a parity fault injector; a second device driven directly.
// Assumes the design files, their header and the checker are compiled first.
`include "cap_params.svh"
`timescale 1ns/1ns
`default_nettype none
module cmd_addr_parity_checker_tb;
   logic clk = 1'b0;
   logic nrst_n = 1'b0;
   logic [4:0] al = 5'h00, write_cas_latency = 5'h00, cl = 5'h00;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, rs = 32'h35;
   logic wr = 1'b0, rd = 1'b0, ev_a, ev_b, pre_b, on_a, on_b;
   logic [6:0] wl_a, rl_a, wl_b, rl_b;
   logic [2:0] pl_a = 3'h0, pl_b = 3'h0;
   cap_pkg::cap_cmd_s cmd_a, cmd_b, c;
   cap_pkg::cap_cmd_s exp_a[$], exp_b[$];
   logic [31:0] exp_rd[$], exp_reg[$];
   int tq[$];
   int errors = 0, checks_done = 0, cyc = 0, nref = 0, nref0;
   logic flip = 1'b0, rd_seen = 1'b0;
   logic [3:0] ops [5] = '{cap_pkg::CAP_RD, cap_pkg::CAP_WR, cap_pkg::CAP_REF, cap_pkg::CAP_PRE, 4'h3};
   logic [2:0] pls [3] = '{3'h0, 3'h2, 3'h7};
   cap_if if_a ();
   cap_if if_b ();
   cap_if if_c ();
   always #2 clk = ~clk;
   // Fault injector: flip inverts only the parity device a sees; the host's own parity stays even
   assign if_c.cs_n = if_a.cs_n;
   assign if_c.ca = if_a.ca;
   assign if_c.cmd_parity_in = if_a.cmd_parity_in ^ flip;
   assign if_a.alert_n = if_c.alert_n;
   assign if_a.rd_data = if_c.rd_data;
   assign if_a.rd_valid = if_c.rd_valid;
   cap_host u_cap_host (.CLOCK_I(clk), .NRST_I(nrst_n), .BUS(if_a.host), .ADDR_I(addr), .WDATA_I(wdata),
      .WR_I(wr), .RD_I(rd), .RDATA_O(rdata));
   cap_device u_cap_device (.CLOCK_I(clk), .NRST_I(nrst_n), .BUS(if_c.dev), .ADDED_LAT_I(al),
      .WRITE_CAS_LAT_I(write_cas_latency), .READ_CAS_LAT_I(cl), .EXEC_VALID_O(ev_a), .EXEC_CMD_O(cmd_a),
      .PRECHARGE_ALL_O(), .CHECK_ON_O(on_a), .WRITE_LAT_O(wl_a), .READ_LAT_O(rl_a));
   cap_device u_cap_device_b (.CLOCK_I(clk), .NRST_I(nrst_n), .BUS(if_b.dev), .ADDED_LAT_I(al),
      .WRITE_CAS_LAT_I(write_cas_latency), .READ_CAS_LAT_I(cl), .EXEC_VALID_O(ev_b), .EXEC_CMD_O(cmd_b),
      .PRECHARGE_ALL_O(pre_b), .CHECK_ON_O(on_b), .WRITE_LAT_O(wl_b), .READ_LAT_O(rl_b));
   cap_assertions u_cap_assertions (.CLOCK_I(clk), .NRST_I(nrst_n), .cs_n(if_a.cs_n), .ca(if_a.ca),
      .cmd_parity_in(if_a.cmd_parity_in), .dev_parity_in(if_c.cmd_parity_in), .alert_n(if_a.alert_n),
      .rd_data(if_a.rd_data),
      .rd_valid(if_a.rd_valid));
   function logic [31:0] nxt();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction
   // Bank group top bit kept low so no random command hits the log select; none uses the mode register op
   function cap_pkg::cap_cmd_s rcmd(input logic [3:0] op);
      logic [31:0] r;
      r = nxt();
      return {op, 1'b0, r[16:0]};
   endfunction
   function cap_pkg::cap_cmd_s mrs(input logic [2:0] pl, input logic st, input logic pers);
      return {cap_pkg::CAP_MRS, `CAP_MR5_SEL, 4'h0, pers, 4'h0, st, 1'b0, pl};
   endfunction
   function logic keep(input cap_pkg::cap_cmd_s k);
      return {k.act_n, k.ras, k.cas, k.we} != cap_pkg::CAP_MRS && {k.bg, k.ba} != `CAP_LOG_SEL;
   endfunction
   task chk(input logic ok, input string m);
      checks_done++;
      if (ok !== 1'b1) begin
         errors++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   task wreg(input logic [3:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      rd <= 1'b0;
      @(posedge clk);
   endtask
   task quiet();
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
   endtask
   // Leaves the read strobe up so reads may follow back to back; end a run with quiet or wreg
   task rreg(input logic [3:0] a, input logic [31:0] e);
      exp_reg.push_back(e);
      addr <= a;
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clk);
   endtask
   // Released lines carry the inverse of the last command, not a held value
   task send_b(input cap_pkg::cap_cmd_s k, input logic bad, input logic runs);
      if (runs) exp_b.push_back(k);
      if_b.cs_n <= 1'b0;
      if_b.ca <= k;
      if_b.cmd_parity_in <= ^k ^ bad;
      @(posedge clk);
      if_b.cs_n <= 1'b1;
      if_b.ca <= ~k;
      if_b.cmd_parity_in <= rs[0];
      @(posedge clk);
   endtask
   task lat();
      logic [31:0] r;
      r = nxt();
      al <= r[4:0];
      write_cas_latency <= r[9:5];
      cl <= r[14:10];
      repeat (2) @(posedge clk);
      chk(wl_a === 7'(al) + 7'(write_cas_latency) + 7'(pl_a) && rl_a === 7'(al) + 7'(cl) + 7'(pl_a), "latency a");
      chk(wl_b === 7'(al) + 7'(write_cas_latency) + 7'(pl_b) && rl_b === 7'(al) + 7'(cl) + 7'(pl_b), "latency b");
   endtask
   task drain();
      int i;
      for (i = 0; i < 100 && exp_a.size() + exp_b.size() + exp_rd.size() + exp_reg.size() != 0; i++) @(posedge clk);
      chk(exp_a.size() + exp_b.size() + exp_rd.size() + exp_reg.size() == 0, "result missing");
   endtask
   task alert_b();
      int i, lo;
      logic pre;
      lo = 0;
      pre = 1'b0;
      #1 chk(if_b.alert_n === 1'b0, "alert not raised");
      for (i = 0; i < 60 && if_b.alert_n !== 1'b1; i++) begin
         @(posedge clk);
         #1 lo++;
         pre = pre | pre_b;
      end
      chk(lo >= `CAP_PW_MIN_CYC - 1 && lo < 40 && pre === 1'b1, "alert width or precharge");
      repeat (40) @(posedge clk);
   endtask
   task log_b(input cap_pkg::cap_cmd_s e, input logic st, input logic multi);
      exp_rd.push_back({8'h00, multi, st, e});
      send_b({cap_pkg::CAP_RD, `CAP_LOG_SEL, 14'h0}, 1'b0, 1'b0);
      drain();
   endtask
   always @(posedge clk) begin
      cyc++;
      // Only commands the bench expects to run get a time stamp; dropped ones would skew the queue
      if (nrst_n && !if_a.cs_n && keep(if_a.ca) && tq.size() < exp_a.size()) tq.push_back(cyc);
      if (nrst_n && !if_a.cs_n && if_a.ca[21:18] == cap_pkg::CAP_REF) nref++;
      if (rd_seen) begin
         chk(exp_reg.size() > 0 && rdata === exp_reg[0], "register read");
         void'(exp_reg.pop_front());
      end
      rd_seen = rd;
      if (ev_a === 1'b1 && keep(cmd_a)) begin
         chk(exp_a.size() > 0 && cmd_a === exp_a[0] && cyc - tq[0] == int'(pl_a) + 1, "command a");
         void'(exp_a.pop_front());
         void'(tq.pop_front());
      end
      if (ev_b === 1'b1 && keep(cmd_b)) begin
         chk(exp_b.size() > 0 && cmd_b === exp_b[0], "command b");
         void'(exp_b.pop_front());
      end
      if (if_b.rd_valid === 1'b1) begin
         chk(exp_rd.size() > 0 && if_b.rd_data === exp_rd[0], "error log");
         void'(exp_rd.pop_front());
      end
   end
   task give_verdict();
      $display("errors %0d checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #100000;
      errors++;
      give_verdict();
   end
   initial begin
      if_b.cs_n = 1'b1;
      if_b.ca = '0;
      if_b.cmd_parity_in = 1'b0;
      repeat (5) @(posedge clk);
      nrst_n <= 1'b1;
      for (int p = 0; p < 3; p++) begin
         wreg(`CAP_REG_CMD, {10'h0, mrs(pls[p], 1'b0, 1'b0)});
         quiet();
         repeat (40) @(posedge clk);
         rreg(`CAP_REG_PL, {29'h0, pls[p]});
         quiet();
         pl_a = pls[p];
         lat();
         chk(on_a === (pls[p] != 3'h0), "checking enable");
         for (int k = 0; k < 5; k++) begin
            c = rcmd(ops[k]);
            exp_a.push_back(c);
            wreg(`CAP_REG_CMD, {10'h0, c});
            quiet();
            drain();
         end
      end
      c = rcmd(ops[0]);
      exp_a.push_back(c);
      wreg(`CAP_REG_CMD, {10'h0, c});
      wreg(`CAP_REG_CMD, {10'h0, rcmd(ops[1])});
      quiet();
      drain();
      rreg(`CAP_REG_STATUS, 32'h4);
      wreg(`CAP_REG_STATUS, 32'h4);
      quiet();
      rreg(`CAP_REG_STATUS, 32'h0);
      rreg(4'h2, 32'h0);
      c = rcmd(ops[0]);
      nref0 = nref;
      flip <= 1'b1;
      wreg(`CAP_REG_CMD, {10'h0, c});
      quiet();
      @(posedge clk);
      flip <= 1'b0;
      repeat (60) @(posedge clk);
      chk(nref == nref0 + `CAP_EXTRA_REFRESH, "extra refresh");
      rreg(`CAP_REG_STATUS, 32'h2);
      wreg(`CAP_REG_CMD, {10'h0, cap_pkg::CAP_RD, `CAP_LOG_SEL, 14'h0});
      quiet();
      repeat (20) @(posedge clk);
      rreg(`CAP_REG_READOUT, {8'h00, 1'b0, 1'b1, c});
      quiet();
      send_b(rcmd(ops[0]), 1'b1, 1'b1);
      drain();
      chk(if_b.alert_n === 1'b1, "alert while checking off");
      send_b(mrs(3'h3, 1'b0, 1'b0), 1'b0, 1'b0);
      repeat (12) @(posedge clk);
      pl_b = 3'h3;
      lat();
      chk(on_b === 1'b1, "checking enable b");
      send_b(rcmd(ops[1]), 1'b0, 1'b1);
      drain();
      c = rcmd(ops[0]);
      send_b(c, 1'b1, 1'b0);
      alert_b();
      log_b(c, 1'b1, 1'b0);
      send_b(rcmd(ops[1]), 1'b1, 1'b1);
      drain();
      chk(if_b.alert_n === 1'b1, "alert while status set");
      send_b(mrs(3'h3, 1'b0, 1'b0), 1'b0, 1'b0);
      repeat (12) @(posedge clk);
      send_b(mrs(3'h3, 1'b1, 1'b0), 1'b0, 1'b0);
      repeat (12) @(posedge clk);
      c = rcmd(ops[2]);
      send_b(c, 1'b1, 1'b0);
      alert_b();
      log_b(c, 1'b1, 1'b0);
      send_b(mrs(3'h3, 1'b1, 1'b1), 1'b0, 1'b0);
      repeat (12) @(posedge clk);
      c = rcmd(ops[3]);
      send_b(c, 1'b1, 1'b0);
      alert_b();
      log_b(c, 1'b1, 1'b1);
      nrst_n <= 1'b0;
      repeat (2) @(posedge clk);
      nrst_n <= 1'b1;
      pl_a = 3'h0;
      pl_b = 3'h0;
      chk(if_b.alert_n === 1'b1, "alert after reset");
      log_b('0, 1'b0, 1'b0);
      give_verdict();
   end
endmodule
`default_nettype wire
